// >>> isoct_top.sv
// isolated counter/timer control: routing, timebase, flags, apb registers
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------------------------
// down counter, one per channel
// ---------------------------------------------------------------
module isoct_down_cnt (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // control
   input wire logic tick,
   input wire logic gate,
   input wire logic load,
   input wire logic [15:0] loadVal,
   // status
   output logic out,
   output logic [15:0] count
);
   import isoct_pkg::*;

   typedef struct packed {
      logic [15:0] count;
      logic [15:0] reload;
      logic armed;
      logic out;
   } isoct_cnt_state_t;

   isoct_cnt_state_t r, next_r;

   // rate generator: output low for the last count, then reload
   always_comb begin
      next_r = r;
      if (load) begin
         next_r.count = loadVal;
         next_r.reload = loadVal;
         next_r.armed = 1'b1;
         next_r.out = 1'b1;
      end else if (r.armed && gate && tick) begin
         if (r.count <= COUNT_ONE) begin
            next_r.count = r.reload;
            next_r.out = 1'b1;
         end else begin
            next_r.count = r.count - COUNT_ONE;
            next_r.out = ((r.count - COUNT_ONE) != COUNT_ONE);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         r <= '0;
         r.out <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign out = r.out;
   assign count = r.count;

endmodule : isoct_down_cnt

// ---------------------------------------------------------------
// top level
// ---------------------------------------------------------------
module isoct_top (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // isolated field lines, output 1 means sinking
   input wire logic [3:0] isoInputs,
   output logic [3:0] isoOutputs,
   // board level
   input wire logic hotReset,
   input wire logic hotResetOutputStrap,
   output logic sysTimerOut
);
   import isoct_pkg::*;

   localparam int ChkTbGap = TB_DIV;

   typedef struct packed {
      logic [3:0] syncA;
      logic [3:0] syncB;
      logic [3:0] syncC;
      logic [6:0] preDiv;
      logic [3:0] div10k;
      logic [3:0] div1k;
      logic [3:0] div100;
      logic tick100k;
      logic tick10k;
      logic tick1k;
      logic tick100;
      logic [7:0] set0;
      logic [7:0] set1;
      logic gate0;
      logic gate1;
      logic [1:0] flags;
      logic [7:0] modeByte;
      logic [1:0] msbNext;
      logic [1:0] rdHigh;
      logic [7:0] lsb0;
      logic [7:0] lsb1;
      logic [1:0] load;
      logic [15:0] loadVal;
      logic [3:0] doData;
      logic [3:0] isoOut;
      logic keepStrap;
      logic sysLoad;
      logic sysDone;
      logic sysOut;
      logic [1:0] outPrev;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } isoct_state_t;

   isoct_state_t r, next_r;

   logic c0Out, c1Out, c2Out;
   logic [15:0] c0Count, c1Count;
   logic intTick, tick0, tick1, gateSel0, gateSel1;
   logic fall0, fall1, setFlag0, setFlag1, cascade;
   logic [3:0] extRise;

   // ---------------------------------------------------------------
   // counter channels
   // ---------------------------------------------------------------
   isoct_down_cnt u_cnt0 (
      .clk(clk), .rst_b(rst_b), .tick(tick0), .gate(gateSel0),
      .load(r.load[0]), .loadVal(r.loadVal), .out(c0Out), .count(c0Count)
   );

   isoct_down_cnt u_cnt1 (
      .clk(clk), .rst_b(rst_b), .tick(tick1), .gate(gateSel1),
      .load(r.load[1]), .loadVal(r.loadVal), .out(c1Out), .count(c1Count)
   );

   // system channel: no register path reaches it
   isoct_down_cnt u_cnt2 (
      .clk(clk), .rst_b(rst_b), .tick(r.tick100k), .gate(1'b1),
      .load(r.sysLoad), .loadVal(SYS_COUNT_DEF), .out(c2Out), .count()
   );

   // ---------------------------------------------------------------
   // source selection
   // ---------------------------------------------------------------
   always_comb begin
      // edge taken from the second and third stages only
      extRise = r.syncB & ~r.syncC;
      case ({r.set1[SET_TB_HI_BIT], r.set1[SET_TB_LO_BIT]})
         TB_SEL_100K: intTick = r.tick100k;
         TB_SEL_10K: intTick = r.tick10k;
         TB_SEL_1K: intTick = r.tick1k;
         TB_SEL_100: intTick = r.tick100;
         default: intTick = r.tick100k;
      endcase
      cascade = r.set1[SET_CASC_BIT];
      fall0 = r.outPrev[0] & ~c0Out;
      fall1 = r.outPrev[1] & ~c1Out;
      tick0 = r.set0[SET_CLK_BIT] ? extRise[DI_CLK0] : intTick;
      if (cascade) begin
         tick1 = fall0;
      end else begin
         tick1 = r.set1[SET_CLK_BIT] ? extRise[DI_CLK1] : intTick;
      end
      gateSel0 = r.set0[SET_GATE_BIT] ? r.syncB[DI_GATE0] : r.gate0;
      gateSel1 = r.set1[SET_GATE_BIT] ? r.syncB[DI_GATE1] : r.gate1;
      // lower half of a cascade raises no flag of its own
      setFlag0 = fall0 & r.set0[SET_IRQ_BIT] & ~cascade;
      setFlag1 = fall1 & r.set1[SET_IRQ_BIT];
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   logic setup, access, wrEn, rdEn, mapped;
   logic [9:0] idx;
   logic [7:0] rdByte;
   logic [3:0] doBits;

   always_comb begin
      next_r = r;
      idx = paddr[11:2];
      setup = psel && !penable;
      access = psel && penable && r.pready;
      mapped = 1'b1;
      rdByte = BYTE_RST;
      case (idx)
         IDX_DO_DATA: rdByte = {NIBBLE_RST, r.isoOut};
         IDX_FLAGS: begin
            rdByte[FLAG_CNT0_BIT] = r.flags[0];
            rdByte[FLAG_CNT1_BIT] = r.flags[1];
         end
         IDX_CNT0_DATA: rdByte = r.rdHigh[0] ? c0Count[15:8] : c0Count[7:0];
         IDX_CNT1_DATA: rdByte = r.rdHigh[1] ? c1Count[15:8] : c1Count[7:0];
         IDX_MODE: rdByte = r.modeByte;
         IDX_START0: begin
            rdByte[START_GATE_BIT] = r.gate0;
            rdByte[START_OUT_BIT] = c0Out;
         end
         IDX_START1: begin
            rdByte[START_GATE_BIT] = r.gate1;
            rdByte[START_OUT_BIT] = c1Out;
         end
         IDX_SET0: rdByte = {4'h0, r.set0[3:0]};
         IDX_SET1: rdByte = {1'b0, r.set1[6:0]};
         default: mapped = 1'b0;
      endcase
      if (paddr[1:0] != 2'h0) begin
         mapped = 1'b0;
      end
      wrEn = access && pwrite && !r.pslverr;
      rdEn = access && !pwrite && !r.pslverr;

      // apb: one wait-free access phase after setup
      next_r.pready = setup;
      if (setup) begin
         next_r.pslverr = !mapped;
         next_r.prdata = {24'h0, mapped ? rdByte : BYTE_RST};
      end else if (access) begin
         next_r.pslverr = 1'b0;
         next_r.prdata = '0;
      end

      // synchronisers
      next_r.syncA = isoInputs;
      next_r.syncB = r.syncA;
      next_r.syncC = r.syncB;

      // timebase dividers
      next_r.tick100k = 1'b0;
      next_r.tick10k = 1'b0;
      next_r.tick1k = 1'b0;
      next_r.tick100 = 1'b0;
      if (r.preDiv == TB_DIV_LAST) begin
         next_r.preDiv = '0;
         next_r.tick100k = 1'b1;
      end else begin
         next_r.preDiv = r.preDiv + 7'h01;
      end
      if (r.tick100k) begin
         next_r.div10k = (r.div10k == DECADE_LAST) ? 4'h0 : r.div10k + 4'h1;
         next_r.tick10k = (r.div10k == DECADE_LAST);
      end
      if (r.tick10k) begin
         next_r.div1k = (r.div1k == DECADE_LAST) ? 4'h0 : r.div1k + 4'h1;
         next_r.tick1k = (r.div1k == DECADE_LAST);
      end
      if (r.tick1k) begin
         next_r.div100 = (r.div100 == DECADE_LAST) ? 4'h0 : r.div100 + 4'h1;
         next_r.tick100 = (r.div100 == DECADE_LAST);
      end

      // system channel loads once after reset
      next_r.sysLoad = !r.sysDone;
      next_r.sysDone = 1'b1;
      next_r.sysOut = c2Out;
      next_r.outPrev = {c1Out, c0Out};
      next_r.load = 2'b00;

      // register writes
      if (wrEn) begin
         case (idx)
            IDX_DO_DATA: next_r.doData = pwdata[3:0];
            IDX_FLAGS: begin
               if (pwdata[FLAG_CNT0_BIT]) next_r.flags[0] = 1'b0;
               if (pwdata[FLAG_CNT1_BIT]) next_r.flags[1] = 1'b0;
            end
            IDX_CNT0_DATA: begin
               if (r.msbNext[0]) begin
                  next_r.loadVal = {pwdata[7:0], r.lsb0};
                  next_r.load[0] = 1'b1;
               end else begin
                  next_r.lsb0 = pwdata[7:0];
               end
               next_r.msbNext[0] = !r.msbNext[0];
            end
            IDX_CNT1_DATA: begin
               if (r.msbNext[1]) begin
                  next_r.loadVal = {pwdata[7:0], r.lsb1};
                  next_r.load[1] = 1'b1;
               end else begin
                  next_r.lsb1 = pwdata[7:0];
               end
               next_r.msbNext[1] = !r.msbNext[1];
            end
            IDX_MODE: begin
               // a word aimed at the system channel is dropped
               case (pwdata[MODE_SEL_HI:MODE_SEL_LO])
                  MODE_SEL_CNT0: begin
                     next_r.modeByte = pwdata[7:0];
                     next_r.msbNext[0] = 1'b0;
                     next_r.rdHigh[0] = 1'b0;
                  end
                  MODE_SEL_CNT1: begin
                     next_r.modeByte = pwdata[7:0];
                     next_r.msbNext[1] = 1'b0;
                     next_r.rdHigh[1] = 1'b0;
                  end
                  default: next_r.modeByte = r.modeByte;
               endcase
            end
            IDX_START0: next_r.gate0 = pwdata[START_GATE_BIT];
            IDX_START1: next_r.gate1 = pwdata[START_GATE_BIT];
            IDX_SET0: next_r.set0 = {4'h0, pwdata[3:0]};
            IDX_SET1: next_r.set1 = {1'b0, pwdata[6:0]};
            default: next_r.doData = r.doData;
         endcase
      end

      // reading a data port walks low byte then high byte
      if (rdEn && idx == IDX_CNT0_DATA) next_r.rdHigh[0] = !r.rdHigh[0];
      if (rdEn && idx == IDX_CNT1_DATA) next_r.rdHigh[1] = !r.rdHigh[1];

      // a new event wins over a clear in the same cycle
      if (setFlag0) next_r.flags[0] = 1'b1;
      if (setFlag1) next_r.flags[1] = 1'b1;

      // strap is only trusted while no hot reset is in progress
      if (!hotReset) next_r.keepStrap = hotResetOutputStrap;
      if (hotReset && !r.keepStrap) begin
         next_r.doData = NIBBLE_RST;
      end

      // output routing
      doBits = next_r.doData;
      if (r.set0[SET_ROUTE_BIT]) doBits[DO_CNT0] = c0Out;
      if (r.set1[SET_ROUTE_BIT]) doBits[DO_CNT1] = c1Out;
      if (hotReset && !r.keepStrap) doBits = NIBBLE_RST;
      next_r.isoOut = doBits;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         r <= '0;
         r.outPrev <= 2'b11;
      end else begin
         r <= next_r;
      end
   end

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign isoOutputs = r.isoOut;
   assign sysTimerOut = r.sysOut;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence seqApbSetup;
      psel && !penable;
   endsequence

   sequence seqApbAnswer;
      r.pready ##1 !r.pready;
   endsequence

   chk_apb_answer: assert property (@(posedge clk) disable iff (!rst_b)
      seqApbSetup |=> seqApbAnswer)
      else $error("apb answer not one cycle after setup");

   chk_power_open: assert property (@(posedge clk) disable iff (!rst_b)
      !$past(rst_b) |-> (isoOutputs == NIBBLE_RST))
      else $error("outputs not open after reset");

   chk_hot_clear: assert property (@(posedge clk) disable iff (!rst_b)
      (hotReset && !r.keepStrap) |=> (isoOutputs == NIBBLE_RST))
      else $error("hot reset did not clear outputs");

   chk_route_cnt0: assert property (@(posedge clk) disable iff (!rst_b)
      (r.set0[SET_ROUTE_BIT] && !hotReset) |=>
         (isoOutputs[DO_CNT0] == $past(c0Out)))
      else $error("counter 0 output not routed");

   chk_flag_set: assert property (@(posedge clk) disable iff (!rst_b)
      setFlag1 |=> r.flags[1] ##1 (r.flags[1] || $past(wrEn)))
      else $error("counter 1 flag not set");

   chk_flag_clear: assert property (@(posedge clk) disable iff (!rst_b)
      (wrEn && idx == IDX_FLAGS && pwdata[FLAG_CNT0_BIT] && !setFlag0)
         |=> !r.flags[0])
      else $error("counter 0 flag not cleared");

   chk_cascade_flag: assert property (@(posedge clk) disable iff (!rst_b)
      (cascade && fall0) |=> !$rose(r.flags[0]))
      else $error("lower half of cascade raised a flag");

   chk_tb_period: assert property (@(posedge clk) disable iff (!rst_b)
      r.tick100k |-> ##ChkTbGap r.tick100k)
      else $error("timebase period wrong");

   chk_sync_delay: assert property (@(posedge clk) disable iff (!rst_b)
      ($past(rst_b) && $past(rst_b, 2)) |->
         (r.syncB == $past(isoInputs, 2)))
      else $error("synchroniser depth wrong");

   chk_sys_ignore: assert property (@(posedge clk) disable iff (!rst_b)
      (wrEn && idx == IDX_MODE && pwdata[MODE_SEL_HI]) |=> $stable(r.modeByte))
      else $error("system channel select was accepted");

endmodule : isoct_top

`default_nettype wire

// >>> isoct_pkg.sv
// constants shared by the isolated counter/timer control block
package isoct_pkg;

   // ---------------------------------------------------------------
   // clock and timebase
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned TB_BASE_HZ = 100_000;
   localparam int unsigned TB_DIV = CLK_HZ / TB_BASE_HZ;
   localparam logic [6:0] TB_DIV_LAST = 7'(TB_DIV - 1);
   localparam logic [3:0] DECADE_LAST = 4'h9;
   localparam logic [1:0] TB_SEL_100K = 2'h0;
   localparam logic [1:0] TB_SEL_10K = 2'h1;
   localparam logic [1:0] TB_SEL_1K = 2'h2;
   localparam logic [1:0] TB_SEL_100 = 2'h3;

   // ---------------------------------------------------------------
   // register indices, byte address is four times the index
   // ---------------------------------------------------------------
   localparam logic [9:0] IDX_DO_DATA = 10'h200;
   localparam logic [9:0] IDX_FLAGS = 10'h207;
   localparam logic [9:0] IDX_CNT0_DATA = 10'h208;
   localparam logic [9:0] IDX_CNT1_DATA = 10'h209;
   localparam logic [9:0] IDX_MODE = 10'h20b;
   localparam logic [9:0] IDX_START0 = 10'h20c;
   localparam logic [9:0] IDX_START1 = 10'h20d;
   localparam logic [9:0] IDX_SET0 = 10'h20e;
   localparam logic [9:0] IDX_SET1 = 10'h20f;

   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int FLAG_CNT0_BIT = 2;
   localparam int FLAG_CNT1_BIT = 3;
   localparam int START_GATE_BIT = 0;
   localparam int START_OUT_BIT = 4;
   localparam int SET_CLK_BIT = 0;
   localparam int SET_GATE_BIT = 1;
   localparam int SET_ROUTE_BIT = 2;
   localparam int SET_IRQ_BIT = 3;
   localparam int SET_TB_LO_BIT = 4;
   localparam int SET_TB_HI_BIT = 5;
   localparam int SET_CASC_BIT = 6;
   localparam int MODE_SEL_LO = 6;
   localparam int MODE_SEL_HI = 7;
   localparam logic [1:0] MODE_SEL_CNT0 = 2'h0;
   localparam logic [1:0] MODE_SEL_CNT1 = 2'h1;
   localparam int DI_GATE0 = 0;
   localparam int DI_CLK0 = 1;
   localparam int DI_GATE1 = 2;
   localparam int DI_CLK1 = 3;
   localparam int DO_CNT0 = 2;
   localparam int DO_CNT1 = 3;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [3:0] NIBBLE_RST = 4'h0;
   localparam logic [15:0] COUNT_ONE = 16'h0001;
   localparam logic [15:0] SYS_COUNT_DEF = 16'h03e8;

endpackage : isoct_pkg

// >>> isoct_field_model.sv
// field side model: gate level and clock bursts on the isolated inputs
`timescale 1ns/100ps
`default_nettype none
module isoct_field_model (
   // control from bench
   input wire logic clk,
   input wire logic run,
   input wire logic gateOn,
   // isolated input lines
   output logic [3:0] lines
);
   logic [3:0] phase = 4'h0;
   // clock line stands low between bursts, one rise every 16 cycles
   always @(posedge clk) begin
      phase <= run ? phase + 4'h1 : 4'h0;
   end
   // both counters see the same burst and gate level
   assign lines = {run & phase[3], gateOn, run & phase[3], gateOn};
endmodule : isoct_field_model
`default_nettype wire

// >>> test_isolated_counter_timer_control.sv
// self-checking bench for the isolated counter/timer control block
`timescale 1ns/100ps
`default_nettype none
module test_isolated_counter_timer_control;
   import isoct_pkg::*;
   logic clk, rst_b, psel, penable, pwrite, hotReset, strap, run, gateOn;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, seed;
   logic pready, pslverr, sysTimerOut;
   logic [3:0] isoInputs, isoOutputs, lastOut;
   logic [7:0] mdl [int];
   logic [7:0] r, d;
   logic e;
   int bad_count = 0, comparisons = 0, n;
   isoct_top dut_u (.clk(clk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .isoInputs(isoInputs),
      .isoOutputs(isoOutputs), .hotReset(hotReset),
      .hotResetOutputStrap(strap), .sysTimerOut(sysTimerOut));
   isoct_field_model field_u (.clk(clk), .run(run), .gateOn(gateOn),
      .lines(isoInputs));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) lastOut <= isoOutputs;
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic chk8(input logic [7:0] g, input logic [7:0] x);
      comparisons++;
      if (g !== x) begin
         bad_count++;
         $display("mismatch t=%0t got %h exp %h", $time, g, x);
      end
   endtask : chk8
   task automatic chkInt(input int g, input int x);
      comparisons++;
      if (g != x) begin
         bad_count++;
         $display("mismatch t=%0t got %h exp %h", $time, g, x);
      end
   endtask : chkInt
   task automatic apb(input logic w, input logic [9:0] idx,
         input logic [7:0] dv, output logic [7:0] rv, output logic ev);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, dv};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rv = prdata[7:0];
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [9:0] idx, input logic [7:0] dv);
      apb(1'b1, idx, dv, r, e);
      chk8({7'h0, e}, 8'h00);
      mdl[idx] = dv;
   endtask : wr
   task automatic rd(input logic [9:0] idx, input logic [7:0] x);
      apb(1'b0, idx, 8'h00, r, e);
      chk8(r, x);
   endtask : rd
   // cycles until the given output falls, lim if it never does
   task automatic fall(input int b, input int lim, output int c);
      c = 1;
      @(posedge clk);
      while (!(isoOutputs[b] === 1'b0 && lastOut[b] === 1'b1) &&
            c < lim) begin
         @(posedge clk);
         c++;
      end
   endtask : fall
   task automatic test_done();
      $display("checks %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done
   initial begin
      repeat (95000) @(posedge clk);
      bad_count++;
      test_done();
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      rst_b = 1'b0;
      {psel, penable, pwrite, hotReset, strap, run, gateOn} = 7'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      seed = 32'haac0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      chk8({4'h0, isoOutputs}, 8'h00);
      rd(IDX_START0, 8'h10);
      rd(IDX_START1, 8'h10);
      chk8({7'h0, sysTimerOut}, 8'h01);
      rd(IDX_FLAGS, 8'h00);
      rd(IDX_SET0, 8'h00);
      rd(IDX_SET1, 8'h00);
      $display("test reset done");
      d = 8'(xs() & 32'h7f);
      wr(IDX_SET1, d);
      rd(IDX_SET1, mdl[IDX_SET1]);
      wr(IDX_SET1, 8'h00);
      apb(1'b0, 10'h20a, 8'h00, r, e);
      chk8({7'h0, e}, 8'h01);
      $display("test registers done");
      d = 8'(xs() & 32'h0f);
      wr(IDX_DO_DATA, d);
      rd(IDX_DO_DATA, d);
      for (int s = 1; s >= 0; s--) begin
         @(posedge clk);
         strap <= s[0];
         @(posedge clk);
         hotReset <= 1'b1;
         repeat (3) @(posedge clk);
         chk8({4'h0, isoOutputs}, s ? d : 8'h00);
         hotReset <= 1'b0;
      end
      $display("test hot reset done");
      wr(IDX_MODE, 8'h34);
      wr(IDX_CNT0_DATA, 8'h02);
      wr(IDX_CNT0_DATA, 8'h00);
      wr(IDX_SET0, 8'h0c);
      wr(IDX_START0, 8'h01);
      fall(DO_CNT0, 1000, n);
      rd(IDX_START0, 8'h01);
      rd(IDX_FLAGS, 8'h04);
      wr(IDX_FLAGS, 8'h04);
      rd(IDX_FLAGS, 8'h00);
      for (int s = 0; s < 3; s++) begin
         wr(IDX_SET1, 8'(s << 4));
         fall(DO_CNT0, 50000, n);
         fall(DO_CNT0, 50000, n);
         chkInt(n, 200 * 10 ** s);
      end
      wr(IDX_SET1, 8'h00);
      wr(IDX_SET0, 8'h04);
      wr(IDX_FLAGS, 8'h04);
      fall(DO_CNT0, 1000, n);
      rd(IDX_FLAGS, 8'h00);
      $display("test timebase done");
      wr(IDX_MODE, 8'h74);
      wr(IDX_MODE, 8'hb4);
      rd(IDX_MODE, 8'h74);
      wr(IDX_CNT1_DATA, 8'h03);
      wr(IDX_CNT1_DATA, 8'h00);
      wr(IDX_SET1, 8'h0f);
      run <= 1'b1;
      fall(DO_CNT1, 300, n);
      chkInt(n, 300);
      rd(IDX_CNT1_DATA, 8'h03);
      rd(IDX_CNT1_DATA, 8'h00);
      gateOn <= 1'b1;
      fall(DO_CNT1, 1000, n);
      fall(DO_CNT1, 1000, n);
      chkInt(n, 48);
      wr(IDX_SET0, 8'h07);
      fall(DO_CNT0, 1000, n);
      fall(DO_CNT0, 1000, n);
      chkInt(n, 32);
      rd(IDX_FLAGS, 8'h08);
      run <= 1'b0;
      $display("test external clock done");
      wr(IDX_SET1, 8'h4c);
      wr(IDX_START1, 8'h01);
      wr(IDX_SET0, 8'h08);
      wr(IDX_FLAGS, 8'h0c);
      fall(DO_CNT1, 2000, n);
      fall(DO_CNT1, 2000, n);
      chkInt(n, 600);
      rd(IDX_FLAGS, 8'h08);
      $display("test cascade done");
      @(posedge clk);
      rst_b <= 1'b0;
      @(posedge clk);
      chk8({4'h0, isoOutputs}, 8'h00);
      rst_b <= 1'b1;
      rd(IDX_SET1, 8'h00);
      $display("test second reset done");
      test_done();
   end
endmodule : test_isolated_counter_timer_control
`default_nettype wire
